// File: design/tie_top.sv
/*
  Interrupt-enable registers of timer channels 0 to 2 with their request gating.
  Assumes flags arrive from timer channel logic on the same clock, standby
  levels come from the clock controller on the same clock, and an Avalon-MM
  master with waitrequest drives the register port.
*/
// The register addresses and the Avalon-MM register port are this design's own decisions.
// Operation
// RL1: Enables zero on reset and standby.
// RL2: Each enable register is 8-bit read/write.
// RL3: Channel 0 bits 7..5 read zero.
// RL4: Channel 0 bit 4 gates overflow.
// RL5: Channel 0 bits 3..0 gate captures D..A.
// RL6: Channel 1 bit 7 reads zero.
// RL7: Channel 1 bit 6 gates overflow.
// RL8: Channel 1 bits 5..0 gate flags F..A.
// RL9: Channel 2 bits 7..3 read zero.
// RL10: Channel 2 bit 2 gates overflow.
// RL11: Channel 2 bits 1..0 gate flags B..A.
// RL12: Request equals flag AND enable.
module tie_top (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Standby modes from the clock controller.
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  // Avalon-MM slave.
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Status flags from the timer channels.
  input  wire logic        ovf_flag_c0,
  input  wire logic [3:0]  cap_flag_c0,
  input  wire logic        ovf_flag_c1,
  input  wire logic [5:0]  capcmp_flag_c1,
  input  wire logic        ovf_flag_c2,
  input  wire logic [1:0]  capcmp_flag_c2,
  // Request lines to the interrupt controller.
  output logic             ovf_irq_c0,
  output logic      [3:0]  cap_irq_c0,
  output logic             ovf_irq_c1,
  output logic      [5:0]  capcmp_irq_c1,
  output logic             ovf_irq_c2,
  output logic      [1:0]  capcmp_irq_c2,
  // Summary interrupt.
  output logic             irq
);

  // Bus handshake states, one-hot.
  typedef enum logic [1:0] {
    TIE_IDLE = 2'b01,
    TIE_ACK  = 2'b10
  } tie_bus_e;

  tie_bus_e    state;           // Current handshake state.
  tie_bus_e    next_state;      // Next handshake state.
  logic [31:0] next_readdata;   // Read data for the next edge.
  logic        next_wait;       // Waitrequest for the next edge.
  logic        commit;          // Request completes at this edge.
  logic        wr_ok;           // A write with the low byte enabled completes.
  logic        standby;         // Either standby mode holds the enables cleared.
  logic [7:0]  en_c0;           // Channel 0 enable register.
  logic [7:0]  en_c1;           // Channel 1 enable register.
  logic [7:0]  en_c2;           // Channel 2 enable register.
  logic [14:0] flags;           // All flags in request order.
  logic [14:0] gate;            // Matching enable bits.
  logic [14:0] req;             // Registered request lines.
  logic [14:0] next_req;        // Request lines for the next edge.
  logic [2:0]  chan_req;        // Any request per channel, combinational.
  logic [2:0]  chan_req_q;      // Same, one cycle late, for edge detection.
  logic [2:0]  evt;             // Rising edge of a channel request.
  logic [2:0]  int_stat;        // Sticky event bits.
  logic [2:0]  int_mask;        // Event mask.

  // Standby is a level from the same clock, so it needs no synchroniser; a write to an enable register
  // that completes during standby is lost, because the clear wins in the register.
  assign standby = hw_standby | sw_standby;

  // The answer comes one cycle after the request is first seen; the master
  // holds it, and the access takes effect at the edge where waitrequest is low.
  assign commit = (read | write) && state == TIE_ACK;
  assign wr_ok  = commit && write && byteenable[0];

  // Handshake and read data. Read data are captured on the first cycle so
  // that they come from a flip-flop and stand at the completing edge.
  always_comb
  begin
    next_state    = state;
    next_wait     = 1'b1;
    next_readdata = readdata;
    case (state)
      TIE_IDLE:
      begin
        if (read || write)
        begin
          next_state    = TIE_ACK;
          next_wait     = 1'b0;
          next_readdata = 32'h0000_0000;
          // Reserved bits of each enable register are zero in storage.
          case (address)
            tie_pkg::OFF_CHAN0_EN:  next_readdata[7:0] = en_c0;  // RL2 RL3
            tie_pkg::OFF_CHAN1_EN:  next_readdata[7:0] = en_c1;  // RL6
            tie_pkg::OFF_CHAN2_EN:  next_readdata[7:0] = en_c2;  // RL9
            tie_pkg::OFF_INT_STAT:  next_readdata[2:0] = int_stat;
            tie_pkg::OFF_INT_MASK:  next_readdata[2:0] = int_mask;
            tie_pkg::OFF_REQ_STATE: next_readdata[14:0] = req;
            // Unmapped offsets read as zero and ignore writes.
            default:                next_readdata = 32'h0000_0000;
          endcase
        end
      end
      TIE_ACK:
      begin
        // The request completes here; return to idle with waitrequest high.
        next_state = TIE_IDLE;
      end
      default:
      begin
        next_state = TIE_IDLE;
      end
    endcase
  end

  // Handshake registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= TIE_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end
    else
    begin
      state       <= next_state;
      waitrequest <= next_wait;
      readdata    <= next_readdata;
    end
  end

  // Enable registers; reserved bits are held zero by their masks.
  tie_enreg #(.WMASK(tie_pkg::C0_WMASK)) u_en_c0 (
    .clk     (clk),
    .rst_n   (rst_n),
    .clr     (standby),  // RL1
    .wr_en   (wr_ok && address == tie_pkg::OFF_CHAN0_EN),
    .wr_data (writedata[7:0]),
    .value   (en_c0)
  );

  tie_enreg #(.WMASK(tie_pkg::C1_WMASK)) u_en_c1 (
    .clk     (clk),
    .rst_n   (rst_n),
    .clr     (standby),  // RL1
    .wr_en   (wr_ok && address == tie_pkg::OFF_CHAN1_EN),
    .wr_data (writedata[7:0]),
    .value   (en_c1)
  );

  tie_enreg #(.WMASK(tie_pkg::C2_WMASK)) u_en_c2 (
    .clk     (clk),
    .rst_n   (rst_n),
    .clr     (standby),  // RL1
    .wr_en   (wr_ok && address == tie_pkg::OFF_CHAN2_EN),
    .wr_data (writedata[7:0]),
    .value   (en_c2)
  );

  // Flags and enables lined up bit for bit: channel 2 on top, channel 0 low.
  assign flags = {ovf_flag_c2, capcmp_flag_c2, ovf_flag_c1, capcmp_flag_c1, ovf_flag_c0, cap_flag_c0};
  assign gate  = {en_c2[tie_pkg::C2_OVF_BIT], en_c2[1:0],  // RL10 RL11
                  en_c1[tie_pkg::C1_OVF_BIT], en_c1[5:0],  // RL7 RL8
                  en_c0[tie_pkg::C0_OVF_BIT], en_c0[3:0]}; // RL4 RL5

  // Each request is the AND of its flag and enable, registered so the
  // outputs are glitch free at the cost of one cycle of latency.
  always_comb
  begin
    next_req = flags & gate;  // RL12
    chan_req = {|next_req[14:12], |next_req[11:5], |next_req[4:0]};
    evt      = chan_req & ~chan_req_q;
  end

  // Request registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req        <= 15'h0000;
      chan_req_q <= 3'h0;
    end
    else
    begin
      req        <= next_req;
      chan_req_q <= chan_req;
    end
  end

  assign {ovf_irq_c2, capcmp_irq_c2, ovf_irq_c1, capcmp_irq_c1, ovf_irq_c0, cap_irq_c0} = req;

  // A new request on a channel sets its sticky bit for the summary interrupt.
  tie_stat #(.N(tie_pkg::EVT_WIDTH)) u_stat (
    .clk     (clk),
    .rst_n   (rst_n),
    .evt     (evt),
    .stat_wr (wr_ok && address == tie_pkg::OFF_INT_STAT),
    .mask_wr (wr_ok && address == tie_pkg::OFF_INT_MASK),
    .wr_data (writedata[2:0]),
    .stat    (int_stat),
    .mask    (int_mask),
    .irq     (irq)
  );

  // Standby empties every enable register by the next edge.
  a_standby_clears: assert property (@(posedge clk) disable iff (!rst_n)  // RL1
    standby |=> (en_c0 == 8'h00 && en_c1 == 8'h00 && en_c2 == 8'h00))
    else $error("enable register not cleared in standby");

  // A completed write to channel 1 is held in its enable register by the next edge, within the mask.
  a_rw_c1_value: assert property (@(posedge clk) disable iff (!rst_n)  // RL2
    (wr_ok && address == tie_pkg::OFF_CHAN1_EN && !standby) |=> en_c1 == ($past(writedata[7:0]) & 8'h7f))
    else $error("channel 1 enable lost a write");

  // Reserved bits of channel 0 never read back as one.
  a_c0_reserved: assert property (@(posedge clk) disable iff (!rst_n)  // RL3
    (commit && read && address == tie_pkg::OFF_CHAN0_EN) |-> readdata[7:5] == 3'h0)
    else $error("channel 0 reserved bits read as one");

  // Channel 0 overflow request follows flag and enable one cycle later.
  a_c0_ovf_gate: assert property (@(posedge clk) disable iff (!rst_n)  // RL4
    ##1 ovf_irq_c0 == ($past(ovf_flag_c0) && $past(en_c0[4])))
    else $error("channel 0 overflow request wrong");

  // Channel 0 capture requests follow their flags and enables.
  a_c0_cap_gate: assert property (@(posedge clk) disable iff (!rst_n)  // RL5
    ##1 cap_irq_c0 == ($past(cap_flag_c0) & $past(en_c0[3:0])))
    else $error("channel 0 capture request wrong");

  // Channel 1 bit 7 and channel 2 bits 7..3 always read zero.
  a_c12_reserved: assert property (@(posedge clk) disable iff (!rst_n)  // RL6 RL9
    (commit && read) |-> !(address == tie_pkg::OFF_CHAN1_EN && readdata[7])
      && !(address == tie_pkg::OFF_CHAN2_EN && readdata[7:3] != 5'h00))
    else $error("reserved bit of channel 1 or 2 read as one");

  // Channel 1 requests follow their flags and enables.
  a_c1_gate: assert property (@(posedge clk) disable iff (!rst_n)  // RL7 RL8
    ##1 {ovf_irq_c1, capcmp_irq_c1} == ($past({ovf_flag_c1, capcmp_flag_c1}) & $past(en_c1[6:0])))
    else $error("channel 1 request wrong");

  // Channel 2 requests follow their flags and enables.
  a_c2_gate: assert property (@(posedge clk) disable iff (!rst_n)  // RL10 RL11
    ##1 {ovf_irq_c2, capcmp_irq_c2} == ($past({ovf_flag_c2, capcmp_flag_c2}) & $past(en_c2[2:0])))
    else $error("channel 2 request wrong");

  // A dropped flag drops its request at the next edge.
  a_flag_drop: assert property (@(posedge clk) disable iff (!rst_n)  // RL12
    $fell(ovf_flag_c1) |=> !ovf_irq_c1)
    else $error("request stayed up after its flag fell");

  // Every request is answered one cycle after it is seen.
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
    ((read || write) && state == TIE_IDLE) |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest timing wrong");

  // Channel 0 keeps a completed write within its writable bits.
  a_rw_c0_value: assert property (@(posedge clk) disable iff (!rst_n)  // RL2 RL3
    (wr_ok && address == tie_pkg::OFF_CHAN0_EN && !standby)
      |=> en_c0 == ($past(writedata[7:0]) & tie_pkg::C0_WMASK))
    else $error("channel 0 enable lost a write");

  // Channel 2 keeps a completed write within its writable bits.
  a_rw_c2_value: assert property (@(posedge clk) disable iff (!rst_n)  // RL2 RL9
    (wr_ok && address == tie_pkg::OFF_CHAN2_EN && !standby)
      |=> en_c2 == ($past(writedata[7:0]) & tie_pkg::C2_WMASK))
    else $error("channel 2 enable lost a write");

  // A write whose low byte lane is off leaves every enable register alone.
  a_lane_off_hold: assert property (@(posedge clk) disable iff (!rst_n)  // RL2
    (commit && write && !byteenable[0] && !standby)
      |=> ($stable(en_c0) && $stable(en_c1) && $stable(en_c2)))
    else $error("enable changed on a write with the low lane off");

  // Two edges after a standby cycle every request line is low.
  a_standby_lines: assert property (@(posedge clk) disable iff (!rst_n)  // RL1 RL12
    standby |-> ##2 req == 15'h0000)
    else $error("request line high after standby");

  // A status bit stays set until software writes a one to it.
  a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (int_stat[1] && !(wr_ok && address == tie_pkg::OFF_INT_STAT && writedata[1])) |=> int_stat[1])
    else $error("status bit lost without a clear");

  // The summary interrupt is high exactly while an unmasked status bit is set.
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(int_stat & int_mask))
    else $error("summary interrupt does not match status and mask");

endmodule : tie_top

// File: design/tie_pkg.sv
/*
  Shared constants of the timer interrupt-enable block: register offsets,
  field positions, writable masks and reset values.
  Assumes a 32-bit Avalon-MM slave port that uses byte addresses.
*/
package tie_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [7:0] OFF_CHAN0_EN   = 8'h00;  // Channel 0 enables.
  localparam logic [7:0] OFF_CHAN1_EN   = 8'h04;  // Channel 1 enables.
  localparam logic [7:0] OFF_CHAN2_EN   = 8'h08;  // Channel 2 enables.
  localparam logic [7:0] OFF_INT_STAT   = 8'h0c;  // Sticky event bits, write one to clear.
  localparam logic [7:0] OFF_INT_MASK   = 8'h10;  // Mask of the event bits.
  localparam logic [7:0] OFF_REQ_STATE  = 8'h14;  // Live request lines, read only.

  // Value of every enable register after reset and in standby.
  localparam logic [7:0] EN_RESET       = 8'h00;

  // Writable bits of each enable register; the others are reserved.
  localparam logic [7:0] C0_WMASK       = 8'h1f;
  localparam logic [7:0] C1_WMASK       = 8'h7f;
  localparam logic [7:0] C2_WMASK       = 8'h07;

  // Position of the overflow enable in each register.
  localparam int         C0_OVF_BIT     = 4;
  localparam int         C1_OVF_BIT     = 6;
  localparam int         C2_OVF_BIT     = 2;

  // Event layout of the status and mask registers: one bit per channel.
  localparam int         EVT_WIDTH      = 3;
  localparam logic [2:0] STAT_RESET     = 3'h0;

  // Number of request lines: 5 for channel 0, 7 for channel 1, 3 for channel 2.
  localparam int         REQ_WIDTH      = 15;

endpackage : tie_pkg

// File: design/tie_enreg.sv
/*
  One 8-bit interrupt-enable register with a per-bit writable mask.
  Assumes the caller decodes the bus write and drives the standby clear.
*/
module tie_enreg #(
  parameter logic [7:0] WMASK = 8'hff  // Bits that software may set.
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       clr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value.
  output logic      [7:0] value
);

  logic [7:0] next_value;  // Value for the next edge.

  // Each bit either loads, clears or holds; reserved bits stay zero always.
  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_bit
      always_comb
      begin
        if (!WMASK[i] || clr)
          next_value[i] = 1'b0;
        else if (wr_en)
          next_value[i] = wr_data[i];
        else
          next_value[i] = value[i];
      end
    end
  endgenerate

  // The register itself, zero out of reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      value <= tie_pkg::EN_RESET;
    else
      value <= next_value;
  end

endmodule : tie_enreg

// File: design/tie_stat.sv
/*
  Sticky event bits with write-one-to-clear, a mask and one level interrupt.
  Assumes one-cycle event pulses from the same clock domain.
*/
module tie_stat #(
  parameter int N = 3  // Number of event bits.
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Events and software access.
  input  wire logic [N-1:0] evt,
  input  wire logic         stat_wr,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] wr_data,
  // State and interrupt.
  output logic      [N-1:0] stat,
  output logic      [N-1:0] mask,
  output logic              irq
);

  logic [N-1:0] next_stat;  // Status for the next edge.
  logic [N-1:0] next_mask;  // Mask for the next edge.
  logic         next_irq;   // Interrupt level for the next edge.

  // Refuse widths that the register port cannot carry, at elaboration.
  generate
    if (N < 1 || N > 8)
    begin : g_bad_n
      $error("tie_stat: N must be 1 to 8");
    end
  endgenerate

  // A set wins over a clear in the same cycle, so no event is lost.
  generate
    for (genvar i = 0; i < N; i++)
    begin : g_evt
      always_comb
      begin
        if (evt[i])
          next_stat[i] = 1'b1;
        else if (stat_wr && wr_data[i])
          next_stat[i] = 1'b0;
        else
          next_stat[i] = stat[i];
      end
    end
  endgenerate

  // Mask loads on write; the output follows the next status so it is registered.
  always_comb
  begin
    next_mask = mask_wr ? wr_data : mask;
    next_irq  = |(next_stat & next_mask);
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat <= N'(tie_pkg::STAT_RESET);
      mask <= N'(tie_pkg::STAT_RESET);
      irq  <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      mask <= next_mask;
      irq  <= next_irq;
    end
  end

endmodule : tie_stat

// File: verification/tie_intc_model.sv
/*
  Behavioural model of the interrupt controller on the far side of the request lines.
  Assumes the request lines are levels on the same clock as the block.
*/
module tie_intc_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request lines from the block.
  input  wire logic [14:0] req,
  // Record of every line seen high since reset.
  output logic      [14:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [14:0] next_seen;  // Record after this cycle.

  // A line seen high at any edge stays recorded, so a one-cycle glitch on a gated line is not lost.
  always_comb
  begin
    next_seen = seen | req;
  end

  // The record only registers the next value.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen <= 15'h0000;  // Nothing recorded after reset.
    end
    else
    begin
      seen <= next_seen;
    end
  end
endmodule : tie_intc_model

// File: verification/tie_top_test.sv
/*
  Self-checking bench of the timer interrupt-enable block.
  Assumes the block answers each Avalon access after a bounded wait.
*/
module tie_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_n;              // Clock and active-low reset.
  logic        hw_standby, sw_standby;  // Standby levels.
  logic [7:0]  address;                 // Bus address.
  logic        read, write;             // Bus requests.
  logic [31:0] writedata, readdata;     // Bus data.
  logic [3:0]  byteenable;              // Byte lanes.
  logic        waitrequest, irq;        // Bus stall and summary interrupt.
  logic [14:0] flags;                   // Packed flags {c2 ovf,B,A, c1 ovf,F..A, c0 ovf,D..A}.
  wire  [14:0] req;                     // Request lines, packed like the flags.
  wire  [14:0] seen;                    // Lines recorded by the controller model.
  logic [7:0]  en_exp [3];              // Expected enable registers.
  logic [31:0] rdata;                   // Scratch read data.
  int          err_count, checked;      // Mismatch and comparison counts.
  localparam logic [7:0] offs [3] = '{tie_pkg::OFF_CHAN0_EN, tie_pkg::OFF_CHAN1_EN, tie_pkg::OFF_CHAN2_EN};

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  tie_top i_dut (.clk(clk), .rst_n(rst_n), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .ovf_flag_c0(flags[4]), .cap_flag_c0(flags[3:0]), .ovf_flag_c1(flags[11]),
    .capcmp_flag_c1(flags[10:5]), .ovf_flag_c2(flags[14]), .capcmp_flag_c2(flags[13:12]),
    .ovf_irq_c0(req[4]), .cap_irq_c0(req[3:0]), .ovf_irq_c1(req[11]), .capcmp_irq_c1(req[10:5]),
    .ovf_irq_c2(req[14]), .capcmp_irq_c2(req[13:12]), .irq(irq));

  tie_intc_model i_intc (.clk(clk), .rst_n(rst_n), .req(req), .seen(seen));

  // Writable bits of one channel's enable register.
  function automatic logic [7:0] wmask(input int ch);
    return (ch == 0) ? tie_pkg::C0_WMASK : (ch == 1) ? tie_pkg::C1_WMASK : tie_pkg::C2_WMASK;
  endfunction : wmask

  // Each line is its flag gated by its enable bit; the enable layouts match the packing.
  function automatic logic [14:0] exp_req(input logic [14:0] f);
    return f & {en_exp[2][2:0], en_exp[1][6:0], en_exp[0][4:0]};
  endfunction : exp_req

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("TB: errors %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Compares a register read.
  task automatic cmp_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg

  // Compares line levels.
  task automatic cmp_line(input string nm, input logic [14:0] e, input logic [14:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_line

  // One Avalon access: held until waitrequest is sampled low; a stall past the bound ends the run.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      err_count++;
      $display("[ERR] waitrequest expected 0 seen stall");
      conclude();
    end
  endtask : bus

  // Full-word write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  // Read and compare.
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    cmp_reg(nm, e, q);
  endtask : chk_rd

  // Lines are registered, so two edges after a change they must equal flag AND enable.
  // The check looks mid-cycle and the task ends on a rising edge, where the next stimulus lands.
  task automatic check_lines();
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_line("request lines", exp_req(flags), req);
    @(posedge clk);
  endtask : check_lines

  // Main sequence.
  initial
  begin
    {rst_n, hw_standby, sw_standby, read, write, address, writedata, flags} = '0;
    byteenable = 4'hf;
    err_count = 0;
    checked = 0;
    en_exp = '{8'h00, 8'h00, 8'h00};
    void'($urandom(32'h96cc));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int ch = 0; ch < 3; ch++) chk_rd("enable reset", offs[ch], 32'h0);
    // Walk every flag, first with all enables zero, then with all writable bits set.
    for (int p = 0; p < 2; p++)
    begin
      for (int b = 0; b < 15; b++)
      begin
        flags <= 15'h0001 << b;
        check_lines();
      end
      flags <= 15'h0000;
      cmp_line("controller record", (p == 0) ? 15'h0000 : 15'h7fff, seen);
      for (int ch = 0; ch < 3 && p == 0; ch++)
      begin
        wr(offs[ch], {24'h0, wmask(ch)});
        en_exp[ch] = wmask(ch);
        chk_rd("enable ones", offs[ch], {24'h0, en_exp[ch]});
      end
    end
    // A write with the low lane off, and an unmapped place.
    bus(1'b1, offs[1], 32'h0, 4'he, rdata);
    chk_rd("lane off", offs[1], {24'h0, en_exp[1]});
    wr(8'h18, 32'hff);
    chk_rd("unmapped", 8'h18, 32'h0);
    // Random enables, reserved bits written as zero, random flags.
    for (int i = 0; i < 60; i++)
    begin
      int ch;
      ch = $urandom_range(2);
      en_exp[ch] = 8'($urandom) & wmask(ch);
      wr(offs[ch], {24'h0, en_exp[ch]});
      chk_rd("enable value", offs[ch], {24'h0, en_exp[ch]});
      flags <= 15'($urandom);
      check_lines();
      chk_rd("request state", tie_pkg::OFF_REQ_STATE, {17'h0, exp_req(flags)});
    end
    // Summary interrupt: a masked event, an unmasked one, then a clear.
    for (int ch = 0; ch < 3; ch++) wr(offs[ch], {24'h0, wmask(ch)});
    en_exp = '{tie_pkg::C0_WMASK, tie_pkg::C1_WMASK, tie_pkg::C2_WMASK};
    flags <= 15'h0000;
    check_lines();
    wr(tie_pkg::OFF_INT_STAT, 32'h7);
    wr(tie_pkg::OFF_INT_MASK, 32'h1);
    flags <= 15'h0020;
    check_lines();
    cmp_line("masked irq", 15'h0, {14'h0, irq});
    flags <= 15'h0021;
    check_lines();
    cmp_line("unmasked irq", 15'h1, {14'h0, irq});
    chk_rd("status", tie_pkg::OFF_INT_STAT, 32'h3);
    chk_rd("mask", tie_pkg::OFF_INT_MASK, 32'h1);
    wr(tie_pkg::OFF_INT_STAT, 32'h1);
    chk_rd("status cleared", tie_pkg::OFF_INT_STAT, 32'h2);
    cmp_line("cleared irq", 15'h0, {14'h0, irq});
    // Each standby mode clears all enables and so drops every line.
    flags <= 15'h7fff;
    for (int s = 0; s < 2; s++)
    begin
      for (int ch = 0; ch < 3; ch++) wr(offs[ch], {24'h0, wmask(ch)});
      en_exp = '{tie_pkg::C0_WMASK, tie_pkg::C1_WMASK, tie_pkg::C2_WMASK};
      check_lines();
      hw_standby <= (s == 0);
      sw_standby <= (s == 1);
      @(posedge clk);
      hw_standby <= 1'b0;
      sw_standby <= 1'b0;
      en_exp = '{8'h00, 8'h00, 8'h00};
      check_lines();
      for (int ch = 0; ch < 3; ch++) chk_rd("enable standby", offs[ch], 32'h0);
    end
    // A reset in mid-run clears written enables.
    wr(offs[1], 32'h7f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int ch = 0; ch < 3; ch++) chk_rd("enable rerun", offs[ch], 32'h0);
    conclude();
  end
endmodule : tie_top_test
